// [hw/psp_regs.svh]
// Operation
// - protocol select resets to 0x02
// - bit 7 set means no receive crc
// - bit 6 picks direct mode variant
// - code bit 0 picks 1-of-4/1-of-256
// - code bit 1 picks low/high rate
// - code bit 2 picks double subcarrier
// - zero pulse length uses protocol width
// - nonzero pulse length times 73.7 ns
// - pulse length cleared on proto write
// - protocol preset pulse width 9.44 us
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

// ****************************************************
// register indices, byte address is four times these
// ****************************************************
`define PSP_IDX_PROTO   6'h01
`define PSP_IDX_PULSE   6'h06
`define PSP_IDX_STATUS  6'h10
`define PSP_IDX_PCOUNT  6'h11

// ****************************************************
// reset values and field positions
// ****************************************************
`define PSP_PROTO_RST   8'h02
`define PSP_PULSE_RST   8'h00
`define PSP_B_RX_CRC_N  7
`define PSP_B_DIR_MODE  6
`define PSP_B_RESERVED  5
`define PSP_B_CODING    0
`define PSP_B_RATE      1
`define PSP_B_DSC       2
`define PSP_B_CODE_HI   4
`define PSP_B_CODE_MID  3

// ****************************************************
// timing in picoseconds, receive rates in 10 bps units
// ****************************************************
`define PSP_CLK_PS      25'h0002710
`define PSP_STEP_PS     25'h0011fe4
`define PSP_PRESET_PS   25'h0900b00
`define PSP_RATE_LO_1   12'h296
`define PSP_RATE_HI_1   12'ha58
`define PSP_RATE_LO_2   12'h29b
`define PSP_RATE_HI_2   12'ha6d

`endif

// [hw/psp_pkg.sv]
package psp_pkg;
   typedef enum logic {PSP_CODING_1OF4, PSP_CODING_1OF256} psp_coding_e;
   typedef enum logic {PSP_RATE_LOW, PSP_RATE_HIGH} psp_rate_e;
   typedef enum logic {PSP_DIRECT_RAW, PSP_DIRECT_FRAMED} psp_dmode_e;
   typedef enum logic [0:0] {PSP_PG_IDLE, PSP_PG_PULSE} psp_pg_state_e;
   typedef logic [24:0] psp_ps_t;
   typedef struct packed {
      logic        rx_crc_check;
      psp_dmode_e  dmode;
      psp_coding_e coding;
      psp_rate_e   rate;
      logic        dual_sub;
      logic        supported;
   } psp_proto_s;
endpackage

// [hw/psp_pulse_if.sv]
`timescale 1ns/1ns
interface psp_pulse_if;
   logic             start;
   psp_pkg::psp_ps_t width_ps;
   logic             active;
   logic             done;
   modport ctl (output start, output width_ps, input active, input done);
   modport gen (input start, input width_ps, output active, output done);
endinterface

// [hw/psp_pulse_gen.sv]
`timescale 1ns/1ns
`include "psp_regs.svh"
module psp_pulse_gen (
   input  wire logic   clk,
   input  wire logic   srst,
   psp_pulse_if.gen    pif
);
   psp_pkg::psp_pg_state_e state_q;
   psp_pkg::psp_ps_t       elapsed_q;
   psp_pkg::psp_ps_t       target_q;
   psp_pkg::psp_ps_t       elapsed_d;
   logic                   done_q;

   assign elapsed_d = elapsed_q + `PSP_CLK_PS;

   // ****************************************************
   // pulse timing
   // ****************************************************
   // width is kept in picoseconds so the 73.7 ns step needs no divider;
   // the pulse lasts the width rounded up to whole clock cycles
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q   <= psp_pkg::PSP_PG_IDLE;
         elapsed_q <= '0;
         target_q  <= '0;
      end else begin
         case (state_q)
            psp_pkg::PSP_PG_IDLE: begin
               if (pif.start) begin
                  state_q   <= psp_pkg::PSP_PG_PULSE;
                  elapsed_q <= '0;
                  target_q  <= pif.width_ps;
               end
            end
            psp_pkg::PSP_PG_PULSE: begin
               elapsed_q <= elapsed_d;
               if (elapsed_d >= target_q) begin
                  state_q <= psp_pkg::PSP_PG_IDLE;
               end
            end
            default: state_q <= psp_pkg::PSP_PG_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (state_q == psp_pkg::PSP_PG_PULSE) && (elapsed_d >= target_q);
      end
   end

   assign pif.active = (state_q == psp_pkg::PSP_PG_PULSE);
   assign pif.done   = done_q;
endmodule // psp_pulse_gen

// [hw/psp_top.sv]
`timescale 1ns/1ns
`include "psp_regs.svh"
module psp_top (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        chip_en,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        tx_pulse_start,
   output logic             mod_pulse,
   output logic             mod_busy,
   output logic             rx_crc_check,
   output logic             direct_mode_framed,
   output logic             reader_mode_ok,
   output logic             proto_supported,
   output logic             coding_1of256,
   output logic             rate_high,
   output logic             double_subcarrier,
   output logic      [11:0] rx_rate_10bps,
   output logic             pulse_from_reg
);
   // ****************************************************
   // declarations
   // ****************************************************
   logic [7:0]          proto_q;
   logic [7:0]          pulse_len_q;
   logic [15:0]         pulse_cnt_q;
   logic                ack_q;
   logic [31:0]         dat_q;
   logic                req;
   logic                wr_lane0;
   logic [5:0]          idx;
   logic                wr_proto;
   logic                wr_pulse;
   logic [31:0]         rd_mux;
   psp_pkg::psp_proto_s dec;
   psp_pkg::psp_ps_t    width_ps;
   logic [11:0]         rate_sel;
   logic [7:0]          out_q;
   logic [11:0]         rate_q;

   psp_pulse_if pif ();

   // ****************************************************
   // bus decode
   // ****************************************************
   // a new request is taken only when no ack is standing, so the
   // master sees exactly one ack per access
   assign req      = wb_cyc_i && wb_stb_i && !ack_q;
   assign idx      = wb_adr_i[7:2];
   assign wr_lane0 = req && wb_we_i && wb_sel_i[0];
   assign wr_proto = wr_lane0 && (idx == `PSP_IDX_PROTO);
   assign wr_pulse = wr_lane0 && (idx == `PSP_IDX_PULSE);

   always_ff @(posedge clk) begin
      if (srst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   // ****************************************************
   // protocol selection register
   // ****************************************************
   // chip enable low holds the register at its default and drops
   // writes; the bus still answers so the host never hangs
   // default load
   always_ff @(posedge clk) begin
      if (srst) begin
         proto_q <= `PSP_PROTO_RST;
      end else if (!chip_en) begin
         proto_q <= `PSP_PROTO_RST;
      end else if (wr_proto) begin
         proto_q <= wb_dat_i[7:0];
      end
   end

   // ****************************************************
   // transmit pulse length register
   // ****************************************************
   // preset on proto write
   always_ff @(posedge clk) begin
      if (srst) begin
         pulse_len_q <= `PSP_PULSE_RST;
      end else if (!chip_en) begin
         pulse_len_q <= `PSP_PULSE_RST;
      end else if (wr_proto) begin
         pulse_len_q <= `PSP_PULSE_RST;
      end else if (wr_pulse) begin
         pulse_len_q <= wb_dat_i[7:0];
      end
   end

   // ****************************************************
   // protocol decode
   // ****************************************************
   always_comb begin
      dec.rx_crc_check = !proto_q[`PSP_B_RX_CRC_N];
      dec.dmode = proto_q[`PSP_B_DIR_MODE] ? psp_pkg::PSP_DIRECT_FRAMED
                                           : psp_pkg::PSP_DIRECT_RAW;
      dec.coding = proto_q[`PSP_B_CODING] ? psp_pkg::PSP_CODING_1OF256
                                          : psp_pkg::PSP_CODING_1OF4;
      dec.rate = proto_q[`PSP_B_RATE] ? psp_pkg::PSP_RATE_HIGH
                                      : psp_pkg::PSP_RATE_LOW;
      dec.dual_sub = proto_q[`PSP_B_DSC];
      dec.supported = !proto_q[`PSP_B_CODE_HI] && !proto_q[`PSP_B_CODE_MID];
   end

   always_comb begin
      case ({dec.dual_sub, dec.rate})
         {1'b0, psp_pkg::PSP_RATE_LOW}:  rate_sel = `PSP_RATE_LO_1;
         {1'b0, psp_pkg::PSP_RATE_HIGH}: rate_sel = `PSP_RATE_HI_1;
         {1'b1, psp_pkg::PSP_RATE_LOW}:  rate_sel = `PSP_RATE_LO_2;
         {1'b1, psp_pkg::PSP_RATE_HIGH}: rate_sel = `PSP_RATE_HI_2;
         default:                        rate_sel = `PSP_RATE_HI_1;
      endcase
   end

   // ****************************************************
   // modulation pulse width
   // ****************************************************
   // width is fixed at the start of each pulse, so a register write
   // during a pulse only affects the next one
   always_comb begin
      if (pulse_len_q == 8'h00) begin
         width_ps = `PSP_PRESET_PS;
      end else begin
         width_ps = psp_pkg::psp_ps_t'(pulse_len_q) * `PSP_STEP_PS;
      end
   end

   // starts arriving while a pulse runs are dropped; the modulator
   // must wait for mod_busy to fall
   assign pif.start    = tx_pulse_start && chip_en && !pif.active;
   assign pif.width_ps = width_ps;

   psp_pulse_gen u_pulse_gen (
      .clk  (clk),
      .srst (srst),
      .pif  (pif)
   );

   // ****************************************************
   // pulse counter
   // ****************************************************
   // wraps silently; software reads differences, not absolutes
   always_ff @(posedge clk) begin
      if (srst) begin
         pulse_cnt_q <= 16'h0000;
      end else if (!chip_en) begin
         pulse_cnt_q <= 16'h0000;
      end else if (pif.done) begin
         pulse_cnt_q <= pulse_cnt_q + 16'h0001;
      end
   end

   // ****************************************************
   // read data
   // ****************************************************
   always_comb begin
      case (idx)
         `PSP_IDX_PROTO:  rd_mux = {24'h000000, proto_q};
         `PSP_IDX_PULSE:  rd_mux = {24'h000000, pulse_len_q};
         `PSP_IDX_STATUS: rd_mux = {12'h000, rate_sel,
                                    2'b00,
                                    pif.active,
                                    (pulse_len_q != 8'h00),
                                    dec.supported,
                                    dec.dual_sub,
                                    (dec.rate == psp_pkg::PSP_RATE_HIGH),
                                    (dec.coding == psp_pkg::PSP_CODING_1OF256)};
         `PSP_IDX_PCOUNT: rd_mux = {16'h0000, pulse_cnt_q};
         default:         rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         dat_q <= 32'h00000000;
      end else if (req && !wb_we_i) begin
         dat_q <= rd_mux;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ****************************************************
   // configuration outputs
   // ****************************************************
   // registered so the front end sees clean levels one cycle after
   // the register itself changes
   always_ff @(posedge clk) begin
      if (srst) begin
         out_q  <= 8'h00;
         rate_q <= 12'h000;
      end else begin
         out_q  <= {dec.rx_crc_check,
                    (dec.dmode == psp_pkg::PSP_DIRECT_FRAMED),
                    !proto_q[`PSP_B_RESERVED],
                    dec.supported,
                    (dec.coding == psp_pkg::PSP_CODING_1OF256),
                    (dec.rate == psp_pkg::PSP_RATE_HIGH),
                    dec.dual_sub,
                    (pulse_len_q != 8'h00)};
         rate_q <= rate_sel;
      end
   end

   assign rx_crc_check       = out_q[7];
   assign direct_mode_framed = out_q[6];
   assign reader_mode_ok     = out_q[5];
   assign proto_supported    = out_q[4];
   assign coding_1of256      = out_q[3];
   assign rate_high          = out_q[2];
   assign double_subcarrier  = out_q[1];
   assign pulse_from_reg     = out_q[0];
   assign rx_rate_10bps      = rate_q;
   assign mod_pulse          = pif.active;
   assign mod_busy           = pif.active;
endmodule // psp_top

// [test/psp_checker.sv]
`timescale 1ns/1ns
// ****
// register bank checks
// ****
module psp_checker (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        chip_en,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic        wb_ack_o,
   input wire logic        tx_pulse_start,
   input wire logic        mod_pulse,
   input wire logic        rx_crc_check,
   input wire logic        coding_1of256,
   input wire logic        rate_high,
   input wire logic        double_subcarrier,
   input wire logic [11:0] rx_rate_10bps,
   input wire logic        pulse_from_reg
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic [11:0] cnt_q;
   logic        zero_q;
   wire         req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire         pw  = req && wb_we_i && wb_sel_i[0] && chip_en && wb_adr_i[7:2] == 6'h01;
   // length counter; start sample sees the lagged override flag
   always_ff @(posedge clk) begin
      cnt_q <= mod_pulse ? cnt_q + 12'h001 : 12'h000;
      if (tx_pulse_start && chip_en && !mod_pulse) begin
         zero_q <= !pulse_from_reg;
      end
   end
   property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse");
   property p_crc; pw |=> ##1 rx_crc_check == !$past(wb_dat_i[7], 2); endproperty
   a_crc: assert property (p_crc) else $error("crc check wrong");
   property p_code;
      pw |=> ##1 {double_subcarrier, rate_high, coding_1of256} == $past(wb_dat_i[2:0], 2);
   endproperty
   a_code: assert property (p_code) else $error("protocol code wrong");
   property p_clr; pw |=> ##1 !pulse_from_reg; endproperty
   a_clr: assert property (p_clr) else $error("pulse length not cleared");
   property p_dflt;
      !chip_en |=> ##1 rate_high && rx_crc_check && !coding_1of256 && !double_subcarrier
         && !pulse_from_reg;
   endproperty
   a_dflt: assert property (p_dflt) else $error("defaults not loaded");
   property p_rate;
      !$past(srst) && !$past(srst, 2) && !$past(srst, 3) |-> rx_rate_10bps == (double_subcarrier
         ? (rate_high ? 12'ha6d : 12'h29b) : (rate_high ? 12'ha58 : 12'h296));
   endproperty
   a_rate: assert property (p_rate) else $error("rate value wrong");
   property p_start; tx_pulse_start && chip_en && !mod_pulse |=> mod_pulse; endproperty
   a_start: assert property (p_start) else $error("pulse not started");
   property p_len; $fell(mod_pulse) && zero_q |-> cnt_q == 12'h3b0; endproperty
   a_len: assert property (p_len) else $error("preset width wrong");
endmodule // psp_checker
bind psp_top psp_checker psp_checker_i (.*);

// [test/psp_host_model.sv]
`timescale 1ns/1ns
// ****
// host side bus master
// ****
module psp_host_model (
   input  wire logic        clk,
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [7:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      dat,
   input  wire logic        ack,
   input  wire logic [31:0] rdat
);
   initial begin
      {cyc, stb, we, sel, adr, dat} = 47'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [31:0] q);
      int n;
      @(posedge clk);
      {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, 4'h1, 24'h0, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      {cyc, stb, we} <= 3'h0;
      // released lines toggle so stale values never look valid
      {adr, dat} <= ~{a, 24'h0, d};
      if (ack !== 1'b1) begin
         psp_top_tb.miscompares++;
         psp_top_tb.end_sim();
      end
   endtask
endmodule // psp_host_model

// [test/psp_top_tb.sv]
`timescale 1ns/1ns
// ****
// register bank bench
// ****
module psp_top_tb;
   logic        clk = 1'b0, srst = 1'b1, chip_en = 1'b1, start = 1'b0;
   logic        cyc, stb, we, ack, mp, crc, dm, ok, sup, c256, rh, ds, pfr, mb;
   logic [7:0]  adr, v;
   logic [3:0]  sel;
   logic [31:0] dat, rdat, q;
   logic [11:0] rate;
   int          miscompares = 0, compares = 0, seed = 32'h2964ff61, i;
   psp_top psp_top_i (.clk(clk), .srst(srst), .chip_en(chip_en), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .tx_pulse_start(start), .mod_pulse(mp), .mod_busy(mb),
      .rx_crc_check(crc), .direct_mode_framed(dm), .reader_mode_ok(ok), .proto_supported(sup),
      .coding_1of256(c256), .rate_high(rh), .double_subcarrier(ds), .rx_rate_10bps(rate),
      .pulse_from_reg(pfr));
   psp_host_model psp_host_model_i (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
      .sel(sel), .dat(dat), .ack(ack), .rdat(rdat));
   initial forever #5 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      psp_host_model_i.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      psp_host_model_i.xfer(1'b0, a, 8'h00, q);
   endtask
   function automatic logic [18:0] exp_cfg(input logic [7:0] p);
      logic [11:0] r;
      r = p[2] ? (p[1] ? 12'ha6d : 12'h29b) : (p[1] ? 12'ha58 : 12'h296);
      return {~p[7], p[6], ~p[5], p[4:3] == 2'h0, p[0], p[1], p[2], r};
   endfunction
   function automatic int exp_len(input logic [7:0] p);
      return p == 8'h00 ? 32'h3b0 : (p * 32'h11fe4 + 32'h270f) / 32'h2710;
   endfunction
   task automatic pulse(input logic [7:0] p);
      int n;
      int w;
      n = 0;
      w = 0;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      do begin
         @(posedge clk);
         w++;
         if (mp === 1'b1) n++;
         chk("mod_busy", mb, w <= exp_len(p));
      end while ((mp !== 1'b0 || n == 0) && w < 3000);
      chk("pulse_len", n, exp_len(p));
      if (w >= 3000) begin
         miscompares++;
         end_sim();
      end
   endtask
   task automatic cfg(input logic [7:0] p);
      chk("cfg", {crc, dm, ok, sup, c256, rh, ds, rate}, exp_cfg(p));
   endtask
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rd(8'h04);
      chk("proto_rst", q, 32'h02);
      rd(8'h18);
      chk("pulse_rst", q, 32'h00);
      cfg(8'h02);
      pulse(8'h00);
      $display("test reset done");
      for (i = 0; i < 8; i++) begin
         // reserved and upper code bits kept zero
         v = {2'($random(seed)), 3'h0, 3'(i)};
         wr(8'h18, 8'($random(seed)) | 8'h01);
         wr(8'h04, v);
         rd(8'h18);
         chk("pulse_clr", q, 32'h00);
         rd(8'h04);
         chk("proto", q, {24'h0, v});
         cfg(v);
      end
      $display("test codes done");
      for (i = 0; i < 3; i++) begin
         v = i == 0 ? 8'h01 : i == 1 ? 8'hff : 8'($random(seed)) | 8'h02;
         wr(8'h18, v);
         @(posedge clk);
         chk("override", pfr, 1'b1);
         pulse(v);
      end
      rd(8'h44);
      chk("pcount", q, 32'h04);
      $display("test pulse done");
      wr(8'h04, 8'hc7);
      wr(8'h18, 8'h33);
      rd(8'h40);
      chk("status", q, 32'h000a6d1f);
      cfg(8'hc7);
      chip_en <= 1'b0;
      wr(8'h04, 8'h41);
      chip_en <= 1'b1;
      rd(8'h04);
      chk("proto_en", q, 32'h02);
      rd(8'h18);
      chk("pulse_en", q, 32'h00);
      chk("pfr_en", pfr, 1'b0);
      cfg(8'h02);
      rd(8'h40);
      chk("status_en", q, 32'h000a580a);
      rd(8'h44);
      chk("pcount_en", q, 32'h00);
      rd(8'h3c);
      chk("unmapped", q, 32'h00);
      $display("test enable done");
      end_sim();
   end
endmodule // psp_top_tb
